// ---- icad_pkg.sv ----
// Register map, field positions, reset values and timing counts of the two-wire bus interface.
// Assumes an 8-bit register port on the 250 MHz core clock, which is also the divider's input clock.
// Summary of operation
// - Speed bit: 0 standard, 1 fast; kept
// - Standard: SCL period 2x(divider+2) clocks
// - Fast: SCL period 3x(divider+2) clocks
// - Divider in low seven bits, kept
// - Data write starts byte transmission
// - Read direction: first byte received automatically
// - Own address bits 7:1 matched, kept
// - Direction bit ignored when matching address
// - Address byte 01h is never answered
// - Ten-bit mode: low address byte kept
// - Ten-bit mode: bits 2:1 kept
// - Byte done holds SCL until cleared or, as master, until stop requested
// - Address match flag holds SCL low
package icad_pkg;
    // Register offsets
    localparam logic [7:0] A_CTRL = 8'h28;
    localparam logic [7:0] A_ST1 = 8'h29;
    localparam logic [7:0] A_ST2 = 8'h2a;
    localparam logic [7:0] A_SPEED = 8'h2b;
    localparam logic [7:0] A_OWN_LO = 8'h2c;
    localparam logic [7:0] A_OWN_HI = 8'h2d;
    localparam logic [7:0] A_DATA = 8'h2e;
    localparam logic [7:0] A_IRQ_ST = 8'h30;
    localparam logic [7:0] A_IRQ_CLR = 8'h31;
    localparam logic [7:0] A_IRQ_EN = 8'h32;
    // Reset values and masks
    localparam logic [7:0] RST_OWN_HI = 8'h40;
    localparam logic [7:0] MASK_CTRL = 8'h3f;
    localparam logic [7:0] MASK_OWN_HI = 8'hc6;
    localparam logic [7:0] RES_OWN_HI = 8'h39;
    localparam logic [7:0] RES_ST2 = 8'he0;
    // Control bits
    localparam int C_EN = 5;
    localparam int C_ENGC = 4;
    localparam int C_START = 3;
    localparam int C_ACK = 2;
    localparam int C_STOP = 1;
    localparam int C_ITE = 0;
    localparam int SPEED_FAST = 7;
    // Event bits of the interrupt status, clear and enable registers
    localparam int EV_BDONE = 0;
    localparam int EV_MATCH = 1;
    localparam int EV_SB = 2;
    localparam int EV_AF = 3;
    localparam int EV_STOPF = 4;
    localparam int NUM_EV = 5;
    // Bus constants and timing counts
    localparam logic [8:0] DIV_OFFSET = 9'h002;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [7:0] GEN_CALL = 8'h00;
    localparam logic [7:0] NEVER_ADDR = 8'h01;
    localparam logic [1:0] STOP_LAST = 2'h1;
    typedef enum logic [2:0] {ST_IDLE, ST_START, ST_SHIFT, ST_ACK, ST_HOLD, ST_STOP} icad_st_t;
endpackage

// ---- icad_sclgen.sv ----
// SCL waveform generator for master transfers.
// Assumes run is low while SCL is held or the bus is idle, so every byte starts in the low phase.
`timescale 1ns/1ps
module icad_sclgen (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic run,
    input wire logic fast,
    input wire logic [6:0] div,
    output logic scl_low,
    output logic tick
);
    import icad_pkg::*;

    typedef struct packed {
        logic [8:0] cnt;
        logic low;
        logic tick;
    } icad_gen_t;

    icad_gen_t s;
    icad_gen_t n;
    logic [8:0] half;
    logic [8:0] len;
    logic [8:0] seen;

    // Standard mode: both phases div+2; fast mode: low phase doubled
    always_comb begin
        half = {2'h0, div} + DIV_OFFSET;
        len = (fast && s.low) ? {half[7:0], 1'b0} : half;
        n = s;
        n.tick = 1'b0;
        if (!run) begin
            n.cnt = 9'h000;
            n.low = 1'b1;
        end else if (s.cnt + 9'h001 >= len) begin
            n.cnt = 9'h000;
            n.low = ~s.low;
            n.tick = 1'b1;
        end else begin
            n.cnt = s.cnt + 9'h001;
        end
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s <= '0;
            s.low <= 1'b1;
        end else if (ce) begin
            s <= n;
        end
    end

    assign scl_low = s.low;
    assign tick = s.tick;

    // Phase length counted independently of the divider counter
    always_ff @(posedge clk) begin
        if (!resetn) begin
            seen <= 9'h000;
        end else if (ce) begin
            seen <= (!run || n.low != s.low) ? 9'h000 : seen + 9'h001;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    std_phase_a: assert property (run && ce && !fast && n.low != s.low |-> seen + 9'h001 == half)
        else $error("standard SCL phase length wrong");
    fast_low_a: assert property (run && ce && fast && s.low && !n.low |-> seen + 9'h001 == {half[7:0], 1'b0})
        else $error("fast SCL low phase length wrong");
    fast_high_a: assert property (run && ce && fast && !s.low && n.low |-> seen + 9'h001 == half)
        else $error("fast SCL high phase length wrong");
endmodule // icad_sclgen

// ---- icad_core.sv ----
// Two-wire bus interface: registers, address matching, byte engine and master clock.
// Assumes open-drain pads outside: an enable pulls the wire low, the pin inputs are asynchronous.
`timescale 1ns/1ps
module icad_core (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic irq,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe
);
    import icad_pkg::*;

    typedef struct packed {
        logic [1:0] scl_sy;
        logic [1:0] sda_sy;
        logic scl_d;
        logic sda_d;
        logic [7:0] ctrl;
        logic [7:0] speed;
        logic [7:0] own_lo;
        logic [7:0] own_hi;
        logic [7:0] dbuf;
        logic [7:0] shreg;
        logic [3:0] cnt;
        icad_st_t st;
        logic [1:0] step;
        logic addr_ph;
        logic tra;
        logic busy;
        logic msl;
        logic bdone;
        logic amatch;
        logic sb;
        logic af;
        logic nack;
        logic stopf;
        logic gcal;
        logic st1_rd;
        logic buf_full;
        logic rw_dir;
        logic [NUM_EV-1:0] irq_st;
        logic [NUM_EV-1:0] irq_en;
        logic [7:0] rdata;
        logic irq;
        logic scl_oe;
        logic sda_oe;
        logic pin_out;
    } icad_state_t;

    icad_state_t s;
    icad_state_t n;
    logic scl_low;
    logic tick;
    logic run;

    // Slave address check; 01h is refused even when it matches the own address
    function automatic logic addr_hit(input logic [7:0] b, input logic [7:0] own, input logic engc);
        addr_hit = (b != NEVER_ADDR) && ((b[7:1] == own[7:1]) || (engc && b == GEN_CALL));
    endfunction

    // Divider only runs while this end masters SCL; holding restarts it in the low phase
    assign run = s.msl && s.st != ST_IDLE && s.st != ST_HOLD;

    icad_sclgen u_gen (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .run(run),
        .fast(s.speed[SPEED_FAST]),
        .div(s.speed[6:0]),
        .scl_low(scl_low),
        .tick(tick)
    );

    // Next state: pin sampling, register access, byte engine, pin drive, interrupts
    always_comb begin
        logic rise;
        logic fall;
        logic start_c;
        logic stop_c;
        logic ack_drv;
        logic [NUM_EV-1:0] ev_old;
        logic [NUM_EV-1:0] ev_new;
        n = s;
        // Second sync stage feeds every detector; first stage feeds only the second
        n.scl_sy = {s.scl_sy[0], scl_in};
        n.sda_sy = {s.sda_sy[0], sda_in};
        n.scl_d = s.scl_sy[1];
        n.sda_d = s.sda_sy[1];
        rise = s.scl_sy[1] && !s.scl_d;
        fall = !s.scl_sy[1] && s.scl_d;
        start_c = s.scl_sy[1] && s.scl_d && s.sda_d && !s.sda_sy[1];
        stop_c = s.scl_sy[1] && s.scl_d && !s.sda_d && s.sda_sy[1];
        ev_old = {s.stopf, s.af, s.sb, s.amatch, s.bdone};
        n.rdata = 8'h00;
        // Bus busy follows the wire even while disabled
        if (start_c) begin
            n.busy = 1'b1;
        end else if (stop_c) begin
            n.busy = 1'b0;
        end
        // Reads: data stand in the next cycle only; status reads clear flags
        if (rd) begin
            unique case (addr)
                A_CTRL: n.rdata = s.ctrl;
                A_ST1: begin
                    n.rdata = {|ev_old, 1'b0, s.tra, s.busy, s.bdone, s.amatch, s.msl, s.sb};
                    n.st1_rd = 1'b1;
                    n.amatch = 1'b0;
                end
                A_ST2: begin
                    n.rdata = {3'h0, s.af, s.stopf, 2'h0, s.gcal};
                    n.af = 1'b0;
                    n.stopf = 1'b0;
                end
                A_SPEED: n.rdata = s.speed;
                A_OWN_LO: n.rdata = s.own_lo;
                A_OWN_HI: n.rdata = s.own_hi & MASK_OWN_HI;
                A_DATA: begin
                    n.rdata = s.dbuf;
                    if (s.st1_rd) begin
                        n.bdone = 1'b0;
                    end
                    n.st1_rd = 1'b0;
                end
                A_IRQ_ST: n.rdata = {3'h0, s.irq_st};
                A_IRQ_EN: n.rdata = {3'h0, s.irq_en};
                default: n.rdata = 8'h00;
            endcase
        end
        // Writes; disabling keeps speed and addresses but clears the start, ack and interrupt enable control bits
        if (wr) begin
            unique case (addr)
                A_CTRL: n.ctrl = wdata & MASK_CTRL;
                A_SPEED: n.speed = wdata;
                A_OWN_LO: n.own_lo = wdata;
                A_OWN_HI: n.own_hi = wdata & MASK_OWN_HI;
                A_DATA: begin
                    n.dbuf = wdata;
                    n.buf_full = 1'b1;
                    if (s.st1_rd) begin
                        n.bdone = 1'b0;
                        n.sb = 1'b0;
                    end
                    n.st1_rd = 1'b0;
                end
                A_IRQ_CLR: n.irq_st = s.irq_st & ~wdata[NUM_EV-1:0];
                A_IRQ_EN: n.irq_en = wdata[NUM_EV-1:0];
                default: ;
            endcase
        end
        if (!n.ctrl[C_EN]) begin
            // Disabled: transfer state and flags drop, speed and addresses stay
            n.ctrl[C_START] = 1'b0;
            n.ctrl[C_ACK] = 1'b0;
            n.ctrl[C_ITE] = 1'b0;
            n.st = ST_IDLE;
            n.msl = 1'b0;
            n.tra = 1'b0;
            n.bdone = 1'b0;
            n.amatch = 1'b0;
            n.sb = 1'b0;
            n.af = 1'b0;
            n.stopf = 1'b0;
            n.gcal = 1'b0;
            n.st1_rd = 1'b0;
        end else if (start_c && !s.msl) begin
            // Any start seen as slave restarts address reception
            n.st = ST_SHIFT;
            n.addr_ph = 1'b1;
            n.tra = 1'b0;
            n.cnt = 4'h0;
        end else if (stop_c && !s.msl && s.st != ST_IDLE) begin
            n.st = ST_IDLE;
            n.stopf = s.ctrl[C_ACK];
            n.gcal = 1'b0;
            n.tra = 1'b0;
        end else begin
            unique case (s.st)
                ST_IDLE: begin
                    // Master start waits for a free bus
                    if (s.ctrl[C_START] && !s.busy) begin
                        n.st = ST_START;
                        n.msl = 1'b1;
                    end
                end
                ST_START: begin
                    if (tick) begin
                        n.st = ST_HOLD;
                        n.sb = 1'b1;
                        n.ctrl[C_START] = 1'b0;
                        n.tra = 1'b1;
                        n.addr_ph = 1'b1;
                    end
                end
                ST_SHIFT: begin
                    // Sample on SCL rise, move the next bit out on SCL fall
                    if (rise) begin
                        n.cnt = s.cnt + 4'h1;
                        if (!s.tra) begin
                            n.shreg = {s.shreg[6:0], s.sda_sy[1]};
                        end
                    end else if (fall && s.cnt == BITS_PER_BYTE) begin
                        n.st = ST_ACK;
                    end else if (fall && s.tra) begin
                        n.shreg = {s.shreg[6:0], 1'b1};
                    end
                end
                ST_ACK: begin
                    if (rise && s.tra) begin
                        n.nack = s.sda_sy[1];
                        n.af = s.af || s.sda_sy[1];
                    end
                    if (fall) begin
                        n.cnt = 4'h0;
                        if (s.addr_ph && !s.msl) begin
                            if (s.ctrl[C_ACK] && addr_hit(s.shreg, s.own_lo, s.ctrl[C_ENGC])) begin
                                n.amatch = 1'b1;
                                n.tra = s.shreg[0];
                                n.gcal = (s.shreg == GEN_CALL);
                                n.st = ST_HOLD;
                                n.addr_ph = 1'b0;
                                n.buf_full = 1'b0;
                            end else begin
                                n.st = ST_IDLE;
                            end
                        end else if (s.tra && s.nack) begin
                            // Refused byte: a slave lets go, a master waits for stop
                            n.st = s.msl ? ST_HOLD : ST_IDLE;
                        end else if (s.addr_ph) begin
                            n.addr_ph = 1'b0;
                            if (s.rw_dir) begin
                                n.tra = 1'b0;
                                n.st = ST_SHIFT;
                            end else begin
                                n.bdone = 1'b1;
                                n.st = ST_HOLD;
                            end
                        end else begin
                            n.bdone = 1'b1;
                            n.st = ST_HOLD;
                            if (!s.tra) begin
                                n.dbuf = s.shreg;
                            end
                        end
                    end
                end
                ST_HOLD: begin
                    // SCL stays low until every holding flag is cleared by software and, when transmitting, a byte is written, or a master requests a stop
                    if (s.msl && s.ctrl[C_STOP]) begin
                        n.st = ST_STOP;
                        n.step = 2'h0;
                    end else if (!s.amatch && !s.bdone && !s.sb && (!s.tra || s.buf_full)) begin
                        n.st = ST_SHIFT;
                        n.cnt = 4'h0;
                        if (s.tra) begin
                            n.shreg = s.dbuf;
                            n.buf_full = 1'b0;
                            n.rw_dir = s.dbuf[0];
                        end
                    end
                end
                ST_STOP: begin
                    // SDA low under low SCL, release SCL, then release SDA
                    if (tick) begin
                        n.step = s.step + 2'h1;
                        if (s.step == STOP_LAST) begin
                            n.st = ST_IDLE;
                            n.msl = 1'b0;
                            n.tra = 1'b0;
                            n.ctrl[C_STOP] = 1'b0;
                        end
                    end
                end
            endcase
        end
        // Pin drives are registered so the pads never see decode glitches
        ack_drv = n.addr_ph ? (!n.msl && n.ctrl[C_ACK] && addr_hit(n.shreg, n.own_lo, n.ctrl[C_ENGC]))
                            : n.ctrl[C_ACK];
        n.scl_oe = (n.st == ST_HOLD) || (n.st == ST_STOP && n.step == 2'h0) ||
                   (n.msl && scl_low && (n.st == ST_SHIFT || n.st == ST_ACK));
        n.sda_oe = (n.st == ST_START) || (n.st == ST_STOP) || (n.st == ST_HOLD && n.sb) ||
                   (n.st == ST_SHIFT && n.tra && !n.shreg[7]) || (n.st == ST_ACK && !n.tra && ack_drv);
        n.pin_out = 1'b0;
        // Sticky events: a new event wins over a clear written in the same cycle
        ev_new = {n.stopf, n.af, n.sb, n.amatch, n.bdone};
        n.irq_st = n.irq_st | (ev_new & ~ev_old);
        n.irq = n.ctrl[C_ITE] && |(n.irq_st & n.irq_en);
    end

    // Single state register; wires idle high so reset shows no false start
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s <= '0;
            s.own_hi <= RST_OWN_HI;
            s.scl_sy <= 2'h3;
            s.sda_sy <= 2'h3;
            s.scl_d <= 1'b1;
            s.sda_d <= 1'b1;
        end else if (ce) begin
            s <= n;
        end
    end

    assign rdata = s.rdata;
    assign irq = s.irq;
    assign scl_oe = s.scl_oe;
    assign sda_oe = s.sda_oe;
    assign scl_out = s.pin_out;
    assign sda_out = s.pin_out;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_addr_slot;
        s.st == ST_ACK && s.addr_ph && !s.msl && !s.tra;
    endsequence

    sequence s_tx_release;
        s.st == ST_HOLD && s.tra && !s.msl && !s.amatch && !s.bdone && !s.sb && s.buf_full && ce;
    endsequence

    speed_kept_a: assert property (!(wr && addr == A_SPEED) |=> $stable(s.speed))
        else $error("speed config changed without a write");
    div_load_a: assert property (ce && wr && addr == A_SPEED |=> s.speed[6:0] == $past(wdata[6:0]))
        else $error("divider not loaded");
    own_lo_kept_a: assert property ($fell(s.ctrl[C_EN]) |-> s.own_lo == $past(s.own_lo))
        else $error("own low address lost on disable");
    own_lo_load_a: assert property (ce && wr && addr == A_OWN_LO |=> s.own_lo == $past(wdata))
        else $error("own low address not loaded");
    own_hi_kept_a: assert property ($fell(s.ctrl[C_EN]) |-> s.own_hi[2:1] == $past(s.own_hi[2:1]))
        else $error("own high address lost on disable");
    res_own_hi_a: assert property (ce && rd && addr == A_OWN_HI |=> (s.rdata & RES_OWN_HI) == 8'h00)
        else $error("reserved own high bits not zero");
    res_st2_a: assert property (ce && rd && addr == A_ST2 |=> (s.rdata & RES_ST2) == 8'h00)
        else $error("reserved status two bits not zero");
    never_01_a: assert property (s_addr_slot and (s.shreg == NEVER_ADDR) |-> !s.sda_oe)
        else $error("address 01h acknowledged");
    dir_ignored_a: assert property (s_addr_slot and (s.ctrl[C_ACK] && s.shreg[7:1] == s.own_lo[7:1] &&
                                    s.shreg != NEVER_ADDR) |-> s.sda_oe)
        else $error("own address not acknowledged");
    match_hold_a: assert property (s.amatch |-> s.scl_oe)
        else $error("SCL released while address match flag set");
    bdone_hold_a: assert property (s.bdone && !s.msl |-> s.scl_oe)
        else $error("SCL released while byte done flag set");
    buf_write_a: assert property (s_tx_release |=> s.st == ST_SHIFT && s.shreg == $past(s.dbuf))
        else $error("written byte not started");
    rx_capture_a: assert property ($rose(s.bdone) && !s.tra |-> s.dbuf == $past(s.shreg))
        else $error("received byte not captured");
endmodule // icad_core

// ---- icad_bus_master.sv ----
// Behavioural bus master that opens frames, clocks bytes into the interface and closes frames.
// Assumes the testbench resolves both wires with pull-ups; a high output pulls its wire low.
`timescale 1ns/1ps
module icad_bus_master #(
    parameter int HALF = 20
) (
    input wire logic clk,
    input wire logic scl,
    input wire logic sda,
    output logic scl_low,
    output logic sda_low
);
    // Both wires released while idle, so the pull-ups show an idle bus
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    task automatic hold();
        repeat (HALF) @(posedge clk);
    endtask
    // Release SCL and wait, bounded, while the interface stretches it
    task automatic pulse(output logic smp);
        int n;
        n = 0;
        scl_low <= 1'b0;
        while (scl !== 1'b1 && n < 4000) begin
            @(posedge clk);
            n++;
        end
        hold();
        smp = sda;
        // A stretch that never ends poisons the sample so the caller's check fails
        if (n >= 4000) begin
            smp = 1'bx;
        end
        scl_low <= 1'b1;
    endtask
    task automatic start_cond();
        sda_low <= 1'b1;
        hold();
        scl_low <= 1'b1;
        hold();
    endtask
    // MSB first; SDA moves one cycle after SCL falls so the two never change together
    task automatic send_byte(input logic [7:0] b, output logic nack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            @(posedge clk);
            sda_low <= !b[i];
            hold();
            pulse(s);
        end
        @(posedge clk);
        sda_low <= 1'b0;
        hold();
        pulse(nack);
    endtask
    // SDA rises while SCL is high
    task automatic stop_cond();
        @(posedge clk);
        sda_low <= 1'b1;
        hold();
        scl_low <= 1'b0;
        hold();
        sda_low <= 1'b0;
        hold();
    endtask
endmodule // icad_bus_master

// ---- tb_icad_core.sv ----
// Self-checking bench: register map, retention, master clock rate, address matching and interrupt.
// Assumes the core clock also feeds the divider and a model master shares the pulled-up wires.
`timescale 1ns/1ps
module tb_icad_core;
    import icad_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic irq, scl_out, scl_oe, sda_out, sda_oe, p_scl, p_sda;
    int mismatches = 0;
    int num_checks = 0;
    // Open-drain wires: any party pulling wins, otherwise the pull-up
    wire scl = !(scl_oe || p_scl);
    wire sda = !(sda_oe || p_sda);
    always #2 clk = !clk;
    icad_core i_icad_core (.clk(clk), .resetn(resetn), .ce(1'b1), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .irq(irq), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
    icad_bus_master i_icad_bus_master (.clk(clk), .scl(scl), .sda(sda), .scl_low(p_scl), .sda_low(p_sda));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("Checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Register port: one-cycle strobes, read data taken in the cycle after the strobe
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rreg(a, d);
        check(what, d, exp);
    endtask
    task automatic do_reset();
        @(posedge clk);
        resetn <= 1'b0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
    endtask
    // Bounded wait for the SCL pull enable; a hang ends the run
    task automatic wait_oe(input logic v, output int n);
        n = 0;
        while (scl_oe !== v) begin
            @(negedge clk);
            n++;
            if (n > 3000) begin
                mismatches++;
                wrap_up();
            end
        end
    endtask
    task automatic t_regs();
        logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, RST_OWN_HI, 8'h00};
        do_reset();
        for (int i = 0; i < 7; i++) begin
            rchk("reset value", A_CTRL + 8'(i), rv[i]);
        end
        rchk("unmapped", 8'h2f, 8'h00);
        wreg(A_OWN_HI, 8'hff);
        rchk("own_id_high", A_OWN_HI, 8'hc6);
        wreg(A_ST2, 8'hff);
        rchk("status_two", A_ST2, 8'h00);
        $display("Register map test done");
    endtask
    // High address written, interface enabled, speed and low address written, then disabled; settings must survive
    task automatic t_keep();
        do_reset();
        wreg(A_OWN_HI, 8'h46);
        wreg(A_CTRL, 8'h20);
        wreg(A_SPEED, 8'h85);
        wreg(A_OWN_LO, 8'h5b);
        wreg(A_CTRL, 8'h00);
        rchk("speed config", A_SPEED, 8'h85);
        rchk("own_id_low", A_OWN_LO, 8'h5b);
        rchk("own_id_high", A_OWN_HI, 8'h46);
        $display("Retention test done");
    endtask
    // Master address byte: bit order on SDA and SCL period from the divider
    task automatic t_speed(input logic fast);
        logic [7:0] d;
        int n1, n2, per;
        per = (fast ? 3 : 2) * (3 + 2);
        do_reset();
        wreg(A_SPEED, {fast, 7'h03});
        wreg(A_CTRL, 8'h2d);
        wait_oe(1'b1, n1);
        rreg(A_ST1, d);
        check("start flag", 8'(d[0]), 8'h01);
        wreg(A_DATA, 8'ha6);
        for (int i = 0; i < 8; i++) begin
            wait_oe(1'b1, n1);
            wait_oe(1'b0, n2);
            check("address bit", 8'(sda_oe), (~8'ha6 >> (7 - i)) & 8'h01);
            if (i > 0) begin
                check("scl period", 8'(n1 + n2), 8'(per));
            end
        end
        $display("Clock rate test done");
    endtask
    // Slave addressing, interrupt masking, holds and one received byte
    task automatic t_slave(input logic [7:0] own, input logic [7:0] ab, input logic hit);
        logic nack;
        logic [7:0] d;
        do_reset();
        wreg(A_OWN_LO, own);
        wreg(A_CTRL, 8'h25);
        i_icad_bus_master.start_cond();
        i_icad_bus_master.send_byte(ab, nack);
        check("address ack", 8'(nack), 8'(!hit));
        repeat (8) @(negedge clk);
        rreg(A_ST1, d);
        check("match flag", 8'(d[2]), 8'(hit));
        if (hit) begin
            check("masked irq", 8'(irq), 8'h00);
            wreg(A_IRQ_EN, 8'h02);
            repeat (2) @(negedge clk);
            check("irq", 8'(irq), 8'h01);
            wreg(A_IRQ_CLR, 8'h02);
            // A slave transmitter keeps SCL low until its first byte is written
            if (ab[0]) begin
                wreg(A_DATA, 8'hc3);
            end
            repeat (2) @(negedge clk);
            check("irq cleared", 8'(irq), 8'h00);
            check("scl release", 8'(scl_oe), 8'h00);
            check("tx first bit", 8'(sda_oe), 8'h00);
        end
        if (hit && !ab[0]) begin
            i_icad_bus_master.send_byte(8'h3c, nack);
            check("data ack", 8'(nack), 8'h00);
            repeat (8) @(negedge clk);
            rreg(A_ST1, d);
            check("byte done", 8'(d[3]), 8'h01);
            check("hold after status", 8'(scl_oe), 8'h01);
            rchk("data_buffer", A_DATA, 8'h3c);
            repeat (2) @(negedge clk);
            check("hold released", 8'(scl_oe), 8'h00);
        end
        i_icad_bus_master.stop_cond();
        $display("Slave test done");
    endtask
    initial begin
        t_regs();
        t_keep();
        t_speed(1'b0);
        t_speed(1'b1);
        t_slave(8'h5a, 8'h5a, 1'b1);
        t_slave(8'h5a, 8'h5b, 1'b1);
        t_slave(NEVER_ADDR, NEVER_ADDR, 1'b0);
        wrap_up();
    end
endmodule // tb_icad_core
